// ---- hw/dpr_host_pkg.sv ----
// constants and types for the dual-port memory port controller
// Overview of operation
// - keep write strobe or port select high while the address changes
// - output enable high during strobe writes so minimum pulse suffices
// - select memory or flag exclusively, held over the whole enable
// - port select stays high across flag write and read-back
// - blocked writer holds strobe low past collision release by hold time
// - never drive data while the device drives its data pins
// - wait the flag write-to-read interval before reading a flag back
package dpr_host_pkg;
	localparam int CLK_NS = 50;
	localparam int WP_NS = 12;
	localparam int WP_CYC = (WP_NS + CLK_NS - 1) / CLK_NS;
	localparam int HOLD_NS = 12;
	localparam int HOLD_CYC = (HOLD_NS + CLK_NS - 1) / CLK_NS;
	localparam int SWRD_NS = 5;
	localparam int SWRD_CYC = (SWRD_NS + CLK_NS - 1) / CLK_NS;
	localparam int ACCESS_NS = 70;
	localparam int SYNC_CYC = 3;
	localparam int ACCESS_CYC = (ACCESS_NS + CLK_NS - 1) / CLK_NS + SYNC_CYC;
	localparam int STROBE_CYC = WP_CYC + SYNC_CYC;
	localparam logic [4:0] REG_CTRL = 5'h00;
	localparam logic [4:0] REG_ADDR = 5'h04;
	localparam logic [4:0] REG_WDATA = 5'h08;
	localparam logic [4:0] REG_RDATA = 5'h0c;
	localparam logic [4:0] REG_STATE = 5'h10;
	localparam logic [4:0] REG_INT_STAT = 5'h14;
	localparam logic [4:0] REG_INT_MASK = 5'h18;
	localparam int EV_DONE = 0;
	localparam int EV_GRANT = 1;
	localparam int EV_DENY = 2;
	localparam int EV_COLL = 3;
	localparam logic [3:0] INT_MASK_RST = 4'h0;
	typedef enum logic [1:0] {
		OP_RAM_WR = 2'h0,
		OP_RAM_RD = 2'h1,
		OP_SEM_REQ = 2'h2,
		OP_SEM_REL = 2'h3
	} op_t;
	typedef enum logic [2:0] {
		ST_IDLE = 3'h0,
		ST_SETUP = 3'h1,
		ST_STROBE = 3'h3,
		ST_HOLD = 3'h2,
		ST_GAP = 3'h6,
		ST_READ = 3'h7,
		ST_DONE = 3'h5
	} state_t;
	typedef struct packed {
		logic select_n;
		logic flag_select_n;
		logic write_n;
		logic oe_n;
		logic [12:0] addr;
	} pins_t;
endpackage

// ---- hw/dpr_host.sv ----
// controller for one port of an asynchronous dual-port memory
//
// The strobed register port and the address map were decided locally.
`timescale 1ns/10ps
module dpr_host import dpr_host_pkg::*; #(
	parameter int AW = 13,
	parameter int DW = 8
) (
	// clock and reset
	input wire logic clk_in,
	input wire logic rst_n_in,
	// software register port
	input wire logic [4:0] reg_addr_in,
	input wire logic [31:0] reg_wdata_in,
	input wire logic reg_wr_in,
	input wire logic reg_rd_in,
	output logic [31:0] reg_rdata_out,
	output logic irq_out,
	// memory port pins
	output pins_t pins_out,
	output logic [DW-1:0] data_out,
	output logic data_oe_out,
	input wire logic [DW-1:0] data_in,
	input wire logic collision_n_in
);
	state_t state;
	state_t next_state;
	op_t op;
	pins_t pins;
	logic [AW-1:0] addr_reg;
	logic [DW-1:0] wdata_reg;
	logic [DW-1:0] rdata_reg;
	logic [3:0] int_stat;
	logic [3:0] int_mask;
	logic owned;
	logic read_phase;
	logic [7:0] cnt;
	logic [DW-1:0] d1, d2, d3, data_filt;
	logic b1, b2, b3, busy_ok;
	logic [31:0] rdata_q;

	// register decode
	wire wr_ctrl = reg_wr_in && reg_addr_in == REG_CTRL;
	wire go = wr_ctrl && state == ST_IDLE;
	wire is_write = op == OP_RAM_WR || op == OP_SEM_REL;
	wire is_sem = op[1];
	// flag request writes zero first, then reads the flag back
	wire flag_reread = op == OP_SEM_REQ && !read_phase;
	wire write_phase = is_write || flag_reread;
	wire cnt_zero = cnt == 8'h00;
	wire fin_rd = state == ST_DONE;
	wire [3:0] ev;
	assign ev[EV_DONE] = fin_rd || (state == ST_GAP && is_write);
	assign ev[EV_GRANT] = fin_rd && op == OP_SEM_REQ && !data_filt[0];
	assign ev[EV_DENY] = fin_rd && op == OP_SEM_REQ && data_filt[0];
	assign ev[EV_COLL] = state == ST_STROBE && !busy_ok;
	wire [3:0] int_clr = (reg_wr_in && reg_addr_in == REG_INT_STAT) ? reg_wdata_in[3:0] : 4'h0;
	wire [31:0] rd_mux = (reg_addr_in == REG_ADDR) ? {{(32-AW){1'b0}}, addr_reg} :
		(reg_addr_in == REG_WDATA) ? {{(32-DW){1'b0}}, wdata_reg} :
		(reg_addr_in == REG_RDATA) ? {{(32-DW){1'b0}}, rdata_reg} :
		(reg_addr_in == REG_STATE) ? {30'h0, owned, state != ST_IDLE} :
		(reg_addr_in == REG_INT_STAT) ? {28'h0, int_stat} :
		(reg_addr_in == REG_INT_MASK) ? {28'h0, int_mask} : 32'h0;

	// next state
	always_comb begin
		next_state = state;
		case (state)
			ST_IDLE: if (go) next_state = ST_SETUP;
			ST_SETUP: if (write_phase) next_state = ST_STROBE;
				else next_state = ST_READ;
			ST_STROBE: if (cnt_zero) next_state = ST_HOLD;
			ST_HOLD: if (cnt_zero && busy_ok) next_state = ST_GAP;
			ST_GAP: if (cnt_zero) next_state = flag_reread ? ST_SETUP : ST_IDLE;
			ST_READ: if (cnt_zero) next_state = ST_DONE;
			ST_DONE: next_state = ST_IDLE;
			default: next_state = ST_IDLE;
		endcase
	end

	// pin values, all selects high outside an access
	wire active = state == ST_SETUP || state == ST_STROBE || state == ST_HOLD || state == ST_READ;
	wire strobing = state == ST_STROBE || state == ST_HOLD;
	pins_t next_pins;
	always_comb begin
		next_pins.select_n = !(active && !is_sem);
		next_pins.flag_select_n = !(active && is_sem);
		next_pins.write_n = !(next_state == ST_STROBE || next_state == ST_HOLD);
		next_pins.oe_n = next_state != ST_READ;
		next_pins.addr = (state == ST_IDLE) ? addr_reg : pins.addr;
	end
	wire next_data_oe = next_state == ST_STROBE || next_state == ST_HOLD;
	wire [DW-1:0] sem_bits = (op == OP_SEM_REL) ? {DW{1'b1}} : {DW{1'b0}};

	// pin input synchronisers
	always_ff @(posedge clk_in) begin
		if (!rst_n_in) begin
			b1 <= 1'b1;
			b2 <= 1'b1;
			b3 <= 1'b1;
			busy_ok <= 1'b1;
			d1 <= '0;
			d2 <= '0;
			d3 <= '0;
			data_filt <= '0;
		end else begin
			b1 <= collision_n_in;
			b2 <= b1;
			b3 <= b2;
			if (b2 == b3) busy_ok <= b3;
			d1 <= data_in;
			d2 <= d1;
			d3 <= d2;
			if (d2 == d3) data_filt <= d3;
		end
	end

	// sequencer and pins
	always_ff @(posedge clk_in) begin
		if (!rst_n_in) begin
			state <= ST_IDLE;
			op <= OP_RAM_WR;
			cnt <= 8'h00;
			pins <= '{1'b1, 1'b1, 1'b1, 1'b1, 13'h0000};
			data_out <= '0;
			data_oe_out <= 1'b0;
			read_phase <= 1'b0;
		end else begin
			state <= next_state;
			if (state == ST_GAP && next_state == ST_SETUP)
				read_phase <= 1'b1;
			else if (state == ST_IDLE)
				read_phase <= 1'b0;
			pins <= next_pins;
			data_oe_out <= next_data_oe;
			if (go) op <= op_t'(reg_wdata_in[1:0]);
			if (state == ST_SETUP) data_out <= is_sem ? sem_bits : wdata_reg;
			if (next_state != state)
				case (next_state)
					ST_STROBE: cnt <= 8'(STROBE_CYC - 1);
					ST_HOLD: cnt <= 8'(HOLD_CYC - 1);
					ST_GAP: cnt <= 8'(SWRD_CYC - 1);
					ST_READ: cnt <= 8'(ACCESS_CYC - 1);
					default: cnt <= 8'h00;
				endcase
			else if (state == ST_HOLD && !busy_ok)
				cnt <= 8'(HOLD_CYC);
			else if (!cnt_zero)
				cnt <= cnt - 8'h01;
		end
	end
	assign pins_out = pins;

	// software registers
	always_ff @(posedge clk_in) begin
		if (!rst_n_in) begin
			addr_reg <= '0;
			wdata_reg <= '0;
			rdata_reg <= '0;
			int_stat <= 4'h0;
			int_mask <= INT_MASK_RST;
			owned <= 1'b0;
			rdata_q <= 32'h0;
		end else begin
			if (reg_wr_in && reg_addr_in == REG_ADDR) addr_reg <= reg_wdata_in[AW-1:0];
			if (reg_wr_in && reg_addr_in == REG_WDATA) wdata_reg <= reg_wdata_in[DW-1:0];
			if (reg_wr_in && reg_addr_in == REG_INT_MASK) int_mask <= reg_wdata_in[3:0];
			int_stat <= (int_stat & ~int_clr) | ev;
			if (fin_rd) rdata_reg <= data_filt;
			if (fin_rd && op == OP_SEM_REQ) owned <= !data_filt[0];
			if (state == ST_GAP && op == OP_SEM_REL && cnt_zero) owned <= 1'b0;
			rdata_q <= reg_rd_in ? rd_mux : 32'h0;
		end
	end
	assign reg_rdata_out = rdata_q;
	assign irq_out = |(int_stat & int_mask);

	// checks
	addr_stable_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
		$changed(pins.addr) |-> pins.write_n && pins.select_n)
		else $error("address moved during an enable");
	sel_exclusive_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
		!(!pins.select_n && !pins.flag_select_n))
		else $error("memory and flag selected together");
	no_contend_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
		data_oe_out |-> pins.oe_n && !pins.write_n)
		else $error("data driven while device may drive");
	oe_in_write_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
		!pins.write_n |-> pins.oe_n)
		else $error("output enable low in a write");
	sem_no_mem_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
		!pins.flag_select_n |-> pins.select_n)
		else $error("port select low in a flag access");
	flag_gap_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
		$fell(pins.oe_n) && !pins.flag_select_n |-> $past(pins.write_n, 1) && $past(pins.write_n, 2))
		else $error("flag read too soon after write");
	write_pulse_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
		$rose(pins.write_n) |-> $past(!pins.write_n, 1) && $past(!pins.write_n, 2) &&
		$past(!pins.select_n || !pins.flag_select_n, 1))
		else $error("write pulse too short or unselected");
	hold_after_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
		$rose(pins.write_n) |-> $past(busy_ok, 1) && $past(busy_ok, 2))
		else $error("write ended before collision hold");
	grant_read_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
		fin_rd && op == OP_SEM_REQ |=> owned == !$past(data_filt[0]))
		else $error("flag ownership not taken from read-back");
	irq_sticky_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
		ev[EV_DONE] |=> int_stat[EV_DONE])
		else $error("done event lost");
	sem_grant_c: cover property (@(posedge clk_in) disable iff (!rst_n_in) ev[EV_GRANT]);
	sem_deny_c: cover property (@(posedge clk_in) disable iff (!rst_n_in) ev[EV_DENY]);
	coll_hold_c: cover property (@(posedge clk_in) disable iff (!rst_n_in)
		state == ST_HOLD && !busy_ok);
	ram_read_c: cover property (@(posedge clk_in) disable iff (!rst_n_in)
		fin_rd && op == OP_RAM_RD);
endmodule // dpr_host

// ---- tb/dpr_device_model.sv ----
// behavioural model of one port of the dual-port memory
`timescale 1ns/10ps
module dpr_device_model import dpr_host_pkg::*; (
	// clock for sampling only
	input wire logic clk_in,
	// port pins from the controller
	input pins_t pins_in,
	input wire logic [7:0] host_data_in,
	input wire logic host_oe_in,
	// commands from the bench
	input wire logic block_in,
	input wire logic other_owns_in,
	// resolved data wire and collision flag
	output logic [7:0] wire_out,
	output logic drive_out,
	output logic collision_n_out
);
	logic [7:0] mem [0:8191];
	logic [7:0] last = 8'h00;
	logic [7:0] ld = 8'h00;
	logic [12:0] la = 13'h0000;
	logic owned = 1'b0;
	logic armed = 1'b0;
	logic ok = 1'b0;
	logic is_flag = 1'b0;
	wire overlap = !pins_in.write_n && (!pins_in.select_n || !pins_in.flag_select_n);
	wire [7:0] q = !pins_in.select_n ? mem[pins_in.addr] : {8{~owned}};
	assign collision_n_out = ~block_in;
	assign drive_out = !pins_in.oe_n && pins_in.write_n && !(pins_in.select_n && pins_in.flag_select_n);
	assign wire_out = host_oe_in ? host_data_in : (drive_out ? q : ~last);
	always @(posedge clk_in) last <= wire_out;
	always @(negedge clk_in) begin
		if (overlap) begin
			armed <= 1'b1;
			la <= pins_in.addr;
			ok <= collision_n_out;
			is_flag <= pins_in.select_n;
			if (host_oe_in) ld <= wire_out;
		end else if (armed) begin
			armed <= 1'b0;
			if (!is_flag && ok) mem[la] <= ld;
			if (is_flag) owned <= ld[0] ? 1'b0 : (owned | !other_owns_in);
		end
	end
endmodule // dpr_device_model

// ---- tb/dpr_host_bench.sv ----
// self-checking bench for the dual-port memory port controller
`timescale 1ns/10ps
`define check(a, b) begin samples_checked++; if ((a) !== (b)) begin fails++; $display("unexpected at %0t: %h not %h", $time, (a), (b)); end end
module dpr_host_bench import dpr_host_pkg::*;;
	logic clk_in = 1'b0;
	logic rst_n_in = 1'b0;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	logic block = 1'b0;
	logic other = 1'b0;
	logic [4:0] reg_addr = 5'h00;
	logic [31:0] reg_wdata = 32'h0;
	logic [31:0] reg_rdata;
	logic [31:0] rd_val;
	logic irq, d_oe, coll_n, drv;
	logic [7:0] d_out, d_in;
	logic [12:0] prev_addr = 13'h0000;
	pins_t pins;
	int fails = 0;
	int samples_checked = 0;
	dpr_host dpr_host_inst (.clk_in(clk_in), .rst_n_in(rst_n_in), .reg_addr_in(reg_addr),
		.reg_wdata_in(reg_wdata), .reg_wr_in(reg_wr), .reg_rd_in(reg_rd), .reg_rdata_out(reg_rdata),
		.irq_out(irq), .pins_out(pins), .data_out(d_out), .data_oe_out(d_oe), .data_in(d_in),
		.collision_n_in(coll_n));
	dpr_device_model dpr_device_model_inst (.clk_in(clk_in), .pins_in(pins), .host_data_in(d_out),
		.host_oe_in(d_oe), .block_in(block), .other_owns_in(other), .wire_out(d_in),
		.drive_out(drv), .collision_n_out(coll_n));
	initial begin
		forever #25 clk_in = ~clk_in;
	end
	task automatic reg_write(input logic [4:0] a, input logic [31:0] d);
		@(posedge clk_in);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge clk_in);
		reg_wr <= 1'b0;
	endtask
	task automatic reg_read(input logic [4:0] a, output logic [31:0] d);
		@(posedge clk_in);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clk_in);
		reg_rd <= 1'b0;
		@(negedge clk_in);
		d = reg_rdata;
	endtask
	task automatic wait_idle;
		int n;
		logic [31:0] s;
		s = 32'h1;
		n = 0;
		while (s[0] !== 1'b0 && n < 200) begin
			reg_read(REG_STATE, s);
			n++;
		end
		`check(s[0], 1'b0)
	endtask
	task automatic run_op(input op_t op);
		reg_write(REG_INT_STAT, 32'hf);
		reg_write(REG_CTRL, {30'h0, op});
		wait_idle;
		reg_read(REG_INT_STAT, rd_val);
	endtask
	task automatic tally_and_finish;
		$display("checks %0d mismatches %0d", samples_checked, fails);
		if (fails == 0 && samples_checked > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask
	always @(negedge clk_in) begin
		if (rst_n_in) begin
			`check(pins.select_n | pins.flag_select_n, 1'b1)
			`check(d_oe & drv, 1'b0)
			`check(pins.write_n | pins.oe_n, 1'b1)
			if (!pins.write_n) `check(pins.addr, prev_addr)
			prev_addr <= pins.addr;
		end
	end
	initial begin
		#2000000;
		fails++;
		tally_and_finish;
	end
	initial begin
		repeat (6) @(posedge clk_in);
		rst_n_in <= 1'b1;
		`check(pins.write_n & pins.select_n & pins.flag_select_n & pins.oe_n, 1'b1)
		reg_read(REG_INT_MASK, rd_val);
		`check(rd_val, 32'h0)
		reg_read(5'h1c, rd_val);
		`check(rd_val, 32'h0)
		reg_write(REG_INT_MASK, 32'h1);
		reg_write(REG_ADDR, 32'h1fff);
		reg_write(REG_WDATA, 32'ha5);
		run_op(OP_RAM_WR);
		`check(rd_val[3:0], 4'h1)
		`check(irq, 1'b1)
		run_op(OP_RAM_RD);
		reg_read(REG_RDATA, rd_val);
		`check(rd_val[7:0], 8'ha5)
		block <= 1'b1;
		reg_write(REG_ADDR, 32'h0010);
		reg_write(REG_WDATA, 32'h5a);
		reg_write(REG_INT_STAT, 32'hf);
		@(negedge clk_in);
		`check(irq, 1'b0)
		reg_write(REG_CTRL, {30'h0, OP_RAM_WR});
		repeat (20) @(posedge clk_in);
		reg_read(REG_STATE, rd_val);
		`check(rd_val[0], 1'b1)
		`check(pins.write_n, 1'b0)
		block <= 1'b0;
		wait_idle;
		reg_read(REG_INT_STAT, rd_val);
		`check(rd_val[3:0], 4'h9)
		run_op(OP_RAM_RD);
		reg_read(REG_RDATA, rd_val);
		`check(rd_val[7:0], 8'h5a)
		run_op(OP_SEM_REQ);
		`check(rd_val[3:0], 4'h3)
		reg_read(REG_STATE, rd_val);
		`check(rd_val[1], 1'b1)
		run_op(OP_SEM_REL);
		reg_read(REG_STATE, rd_val);
		`check(rd_val[1], 1'b0)
		other <= 1'b1;
		run_op(OP_SEM_REQ);
		`check(rd_val[3:0], 4'h5)
		tally_and_finish;
	end
endmodule // dpr_host_bench
